// *** design/cfg_pkg.sv ***
package cfg_pkg;
  // Host port addresses (10-bit ISA I/O decode) and entry/exit keys
  localparam logic [9:0] INDEX_PORT_ADDR = 10'h3f0;
  localparam logic [9:0] DATA_PORT_ADDR  = 10'h3f1;
  localparam logic [7:0] ENTER_KEY       = 8'h55;
  localparam logic [7:0] EXIT_KEY        = 8'haa;

  // Register indices
  localparam logic [3:0] IDX_FUNC_EN  = 4'h0;
  localparam logic [3:0] IDX_PORT_ADR = 4'h1;
  localparam logic [3:0] IDX_SERIAL   = 4'h2;
  localparam logic [3:0] IDX_EXT      = 4'h4;

  // Power-up defaults
  localparam logic [7:0] FUNC_EN_DEFAULT_A = 8'h3b;
  localparam logic [7:0] FUNC_EN_DEFAULT_B = 8'h2b;
  localparam logic [7:0] PORT_ADR_DEFAULT  = 8'h9f;
  localparam logic [7:0] SERIAL_DEFAULT    = 8'hdc;
  localparam logic [7:0] EXT_DEFAULT       = 8'h00;

  // Field positions
  localparam int FE_IDE_EN   = 0;
  localparam int FE_IDE_AT   = 1;
  localparam int FE_RSVD     = 2;
  localparam int FE_FDC_PWR  = 3;
  localparam int FE_FDC_EN   = 4;
  localparam int FE_OSC_LO   = 5;
  localparam int FE_VALID    = 7;
  localparam int PA_PP_LO    = 0;
  localparam int PA_PP_PWR   = 2;
  localparam int PA_PP_MODE  = 3;
  localparam int PA_IRQ_POL  = 4;
  localparam int PA_SLOT_LO  = 5;
  localparam int PA_LOCK     = 7;
  localparam int SP_U1_LO    = 0;
  localparam int SP_U1_EN    = 2;
  localparam int SP_U1_PWR   = 3;
  localparam int SP_U2_LO    = 4;
  localparam int SP_U2_EN    = 6;
  localparam int SP_U2_PWR   = 7;

  localparam logic [1:0] OSC_ALWAYS_ON = 2'h0;
  localparam logic [1:0] OSC_ALL_OFF   = 2'h3;

  // Decoded base addresses
  localparam logic [9:0] PP_ADDR_1  = 10'h3bc;
  localparam logic [9:0] PP_ADDR_2  = 10'h378;
  localparam logic [9:0] PP_ADDR_3  = 10'h278;
  localparam logic [9:0] SLOT1_ADDR = 10'h3f8;
  localparam logic [9:0] SLOT2_ADDR = 10'h2f8;
  localparam logic [9:0] S3_A0 = 10'h338;
  localparam logic [9:0] S4_A0 = 10'h238;
  localparam logic [9:0] S3_A1 = 10'h3e8;
  localparam logic [9:0] S4_A1 = 10'h2e8;
  localparam logic [9:0] S3_A2 = 10'h2e8;
  localparam logic [9:0] S4_A2 = 10'h2e0;
  localparam logic [9:0] S3_A3 = 10'h220;
  localparam logic [9:0] S4_A3 = 10'h228;

  typedef enum logic [1:0] {
    CM_IDLE  = 2'b00,
    CM_ARMED = 2'b01,
    CM_OPEN  = 2'b10
  } cfg_mode_t;

  typedef struct packed {
    logic       ide_en;
    logic       ide_at;
    logic       fdc_pwr;
    logic       fdc_en;
    logic       osc_on;
    logic       baud_clock_generator_en;
    logic       valid;
  } func_ctl_t;

  typedef struct packed {
    logic       pp_en;
    logic [9:0] pp_base;
    logic       pp_pwr;
    logic       pp_printer_mode;
    logic       uart1_en;
    logic       uart1_pwr;
    logic [9:0] uart1_base;
    logic       uart2_en;
    logic       uart2_pwr;
    logic [9:0] uart2_base;
  } port_ctl_t;
endpackage

// *** design/irq_pol_drive.sv ***
`timescale 1ns/100ps
// Polarity and tristate shaping for one interrupt pin
module irq_pol_drive (
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Sync reset, active low
  input  wire logic req,      // Internal request, active high
  input  wire logic act_high, // Active high, inactive low
  output logic      pin_o,    // Pin level
  output logic      pin_oe    // Pin drive enable
);
  wire pin_o_nxt;
  wire pin_oe_nxt;

  // Low mode drives only while asserted, floats otherwise
  assign pin_o_nxt  = act_high ? req : 1'b0;
  assign pin_oe_nxt = act_high | req;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o  <= pin_o_nxt;
      pin_oe <= pin_oe_nxt;
    end
  end
endmodule

// *** design/superio_config_regs.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Index 0 register reachable only in config mode; default 3Bh or 2Bh.
// - Function bit 0 enables the IDE decode.
// - Function bit 1 picks AT IDE when set, XT when clear.
// - Function bit 3 powers the floppy controller; clear means low power.
// - Function bit 4 enables the floppy controller.
// - Function bits 6:5 gate oscillator and baud clock, 01/10 follow power good.
// - Function bit 7 is a software valid flag, zero at power-up.
// - Index 1 register reachable only in config mode; default 9Fh.
// - Port bits 1:0 pick parallel base: off, 3BCh, 378h, 278h.
// - Port bit 2 powers the parallel port.
// - Port bit 3 set is printer mode; clear enables extended modes.
// - Port bit 4 sets interrupt polarity: high/low or low/float.
// - In ECP or EPP, printer interrupt is always low/float.
// - Port bits 6:5 pick third and fourth serial slot addresses.
// - Port bit 7 clear blocks all config access until power-up.
// - Index 2 register reachable only in config mode; default DCh.
// - Serial bits 1:0 place the primary UART.
// - Serial bit 2 enables the primary UART.
// - Serial bit 3 clear powers down the primary UART.
// - Serial bits 5:4 place the secondary UART.
// - Serial bits 6 and 7 enable and power the secondary UART.
// - Two back-to-back 55h writes to 3F0h enter config mode.
// - Index written to 3F0h selects register accessed at 3F1h.
// - Writing AAh to the index port leaves config mode.
// - Registers load defaults at power-up only, not at ordinary reset.
module superio_config_regs #(
  parameter bit ALT_VARIANT = 1'b0  // Selects the 2Bh function default
) (
  input  wire logic               clk,          // 100 MHz clock
  input  wire logic               rst_n,        // Ordinary reset, low
  input  wire logic               por_n,        // Power-up/hard reset, low
  input  wire logic [9:0]         isa_addr,     // ISA I/O address
  input  wire logic [7:0]         isa_wdata,    // ISA write data
  input  wire logic               isa_iow,      // I/O write strobe, 1 cycle
  input  wire logic               isa_ior,      // I/O read strobe, 1 cycle
  output logic      [7:0]         isa_rdata,    // Read data
  output logic                    isa_rd_hit,   // Read claimed by block
  input  wire logic               power_good,   // Power good pin
  input  wire logic               ext_mode_in,  // Extended parallel mode req
  input  wire logic               serial_irq_a, // Serial interrupt request
  input  wire logic               serial_irq_b, // Serial interrupt request
  input  wire logic               floppy_irq,   // Floppy interrupt request
  input  wire logic               printer_irq,  // Printer interrupt request
  output logic                    config_mode,  // Config mode active
  output cfg_pkg::func_ctl_t      func_ctl,     // Function controls
  output cfg_pkg::port_ctl_t      port_ctl,     // Port decode controls
  output logic      [1:0]         slot_sel,     // Third/fourth slot select
  output logic      [9:0]         slot3_base,   // Third serial slot base
  output logic      [9:0]         slot4_base,   // Fourth serial slot base
  output logic      [3:0]         irq_o,        // Serial a,b, floppy, printer
  output logic      [3:0]         irq_oe        // Interrupt drive enables
);
  // Three-flop pin synchroniser for power good
  logic pg_s1_r, pg_s2_r, pg_s3_r, pg_r;

  // Power-up reset also clears state; registers see only por_n
  logic [7:0] func_r, port_r, serial_r, ext_r;
  logic [3:0] index_r;
  cfg_pkg::cfg_mode_t mode_r, mode_nxt;

  function automatic logic [9:0] uart_base(input logic [1:0] sel,
                                           input logic [9:0] s3,
                                           input logic [9:0] s4);
    case (sel)
      2'b00:   uart_base = cfg_pkg::SLOT1_ADDR;
      2'b01:   uart_base = cfg_pkg::SLOT2_ADDR;
      2'b10:   uart_base = s3;
      default: uart_base = s4;
    endcase
  endfunction

  wire       any_rst_n  = rst_n & por_n;
  wire       idx_wr     = isa_iow & (isa_addr == cfg_pkg::INDEX_PORT_ADDR);
  wire       dat_wr     = isa_iow & (isa_addr == cfg_pkg::DATA_PORT_ADDR);
  wire       dat_rd     = isa_ior & (isa_addr == cfg_pkg::DATA_PORT_ADDR);
  wire       any_acc    = isa_iow | isa_ior;
  wire       is_open    = (mode_r == cfg_pkg::CM_OPEN);
  wire       unlocked   = port_r[cfg_pkg::PA_LOCK];
  wire       cfg_wr     = is_open & unlocked & dat_wr;
  wire       cfg_rd     = is_open & unlocked & dat_rd;
  wire       key_wr     = idx_wr & (isa_wdata == cfg_pkg::ENTER_KEY);
  wire       exit_wr    = idx_wr & (isa_wdata == cfg_pkg::EXIT_KEY);
  wire       wr_func    = cfg_wr & (index_r == cfg_pkg::IDX_FUNC_EN);
  wire       wr_port    = cfg_wr & (index_r == cfg_pkg::IDX_PORT_ADR);
  wire       wr_serial  = cfg_wr & (index_r == cfg_pkg::IDX_SERIAL);
  wire       wr_ext     = cfg_wr & (index_r == cfg_pkg::IDX_EXT);
  wire [7:0] func_dflt  = ALT_VARIANT ? cfg_pkg::FUNC_EN_DEFAULT_B
                                      : cfg_pkg::FUNC_EN_DEFAULT_A;

  // Entry state machine: any other access between keys disarms
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      cfg_pkg::CM_IDLE: begin
        if (key_wr)
          mode_nxt = cfg_pkg::CM_ARMED;
      end
      cfg_pkg::CM_ARMED: begin
        if (key_wr)
          mode_nxt = cfg_pkg::CM_OPEN;
        else if (any_acc)
          mode_nxt = cfg_pkg::CM_IDLE;
      end
      cfg_pkg::CM_OPEN: begin
        if (exit_wr)
          mode_nxt = cfg_pkg::CM_IDLE;
      end
      default: mode_nxt = cfg_pkg::CM_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!any_rst_n)
      mode_r <= cfg_pkg::CM_IDLE;
    else
      mode_r <= mode_nxt;
  end

  // Index written in open mode, excluding the exit key
  always_ff @(posedge clk) begin
    if (!any_rst_n)
      index_r <= cfg_pkg::IDX_FUNC_EN;
    else if (is_open & idx_wr & ~exit_wr)
      index_r <= isa_wdata[3:0];
  end

  // Power-up-only registers; rst_n deliberately not used here
  always_ff @(posedge clk) begin
    if (!por_n) begin
      func_r   <= func_dflt;
      port_r   <= cfg_pkg::PORT_ADR_DEFAULT;
      serial_r <= cfg_pkg::SERIAL_DEFAULT;
      ext_r    <= cfg_pkg::EXT_DEFAULT;
    end else begin
      if (wr_func)
        func_r <= isa_wdata;
      if (wr_port) begin
        port_r <= isa_wdata;
        // Lock bit can only fall; setting it again needs power-up
        port_r[cfg_pkg::PA_LOCK] <= isa_wdata[cfg_pkg::PA_LOCK]
                                    & port_r[cfg_pkg::PA_LOCK];
      end
      if (wr_serial)
        serial_r <= isa_wdata;
      if (wr_ext)
        ext_r <= isa_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
      pg_s3_r <= 1'b0;
      pg_r    <= 1'b0;
    end else begin
      pg_s1_r <= power_good;
      pg_s2_r <= pg_s1_r;
      pg_s3_r <= pg_s2_r;
      if (pg_s2_r == pg_s3_r)
        pg_r <= pg_s3_r;
    end
  end

  // Read mux; unknown indices read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (index_r)
      cfg_pkg::IDX_FUNC_EN:  rd_mux = func_r;
      cfg_pkg::IDX_PORT_ADR: rd_mux = port_r;
      cfg_pkg::IDX_SERIAL:   rd_mux = serial_r;
      cfg_pkg::IDX_EXT:      rd_mux = ext_r;
      default:               rd_mux = 8'h00;
    endcase
  end

  // Decoded controls
  wire [1:0] osc_sel  = func_r[cfg_pkg::FE_OSC_LO +: 2];
  wire       osc_nxt  = (osc_sel == cfg_pkg::OSC_ALWAYS_ON) |
                        ((osc_sel != cfg_pkg::OSC_ALL_OFF) & pg_r);
  wire [1:0] pp_sel   = port_r[cfg_pkg::PA_PP_LO +: 2];
  wire [1:0] slot_nxt = port_r[cfg_pkg::PA_SLOT_LO +: 2];
  logic [9:0] pp_base_nxt, s3_nxt, s4_nxt;

  always_comb begin
    case (pp_sel)
      2'b01:   pp_base_nxt = cfg_pkg::PP_ADDR_1;
      2'b10:   pp_base_nxt = cfg_pkg::PP_ADDR_2;
      default: pp_base_nxt = cfg_pkg::PP_ADDR_3;
    endcase
    case (slot_nxt)
      2'b00:   begin s3_nxt = cfg_pkg::S3_A0; s4_nxt = cfg_pkg::S4_A0; end
      2'b01:   begin s3_nxt = cfg_pkg::S3_A1; s4_nxt = cfg_pkg::S4_A1; end
      2'b10:   begin s3_nxt = cfg_pkg::S3_A2; s4_nxt = cfg_pkg::S4_A2; end
      default: begin s3_nxt = cfg_pkg::S3_A3; s4_nxt = cfg_pkg::S4_A3; end
    endcase
  end

  cfg_pkg::func_ctl_t func_nxt;
  cfg_pkg::port_ctl_t port_nxt;
  always_comb begin
    func_nxt.ide_en   = func_r[cfg_pkg::FE_IDE_EN];
    func_nxt.ide_at   = func_r[cfg_pkg::FE_IDE_AT];
    func_nxt.fdc_pwr  = func_r[cfg_pkg::FE_FDC_PWR];
    func_nxt.fdc_en   = func_r[cfg_pkg::FE_FDC_EN];
    func_nxt.osc_on   = osc_nxt;
    func_nxt.baud_clock_generator_en = osc_nxt;
    func_nxt.valid    = func_r[cfg_pkg::FE_VALID];
    port_nxt.pp_en    = (pp_sel != 2'b00);
    port_nxt.pp_base  = pp_base_nxt;
    port_nxt.pp_pwr   = port_r[cfg_pkg::PA_PP_PWR];
    port_nxt.pp_printer_mode = port_r[cfg_pkg::PA_PP_MODE];
    port_nxt.uart1_en  = serial_r[cfg_pkg::SP_U1_EN];
    port_nxt.uart1_pwr = serial_r[cfg_pkg::SP_U1_PWR];
    port_nxt.uart1_base = uart_base(serial_r[cfg_pkg::SP_U1_LO +: 2],
                                    s3_nxt, s4_nxt);
    port_nxt.uart2_en  = serial_r[cfg_pkg::SP_U2_EN];
    port_nxt.uart2_pwr = serial_r[cfg_pkg::SP_U2_PWR];
    port_nxt.uart2_base = uart_base(serial_r[cfg_pkg::SP_U2_LO +: 2],
                                    s3_nxt, s4_nxt);
  end

  // Extended parallel mode only counts when printer mode is off
  wire ecp_epp  = ~port_r[cfg_pkg::PA_PP_MODE] & ext_mode_in;
  wire pol_high = port_r[cfg_pkg::PA_IRQ_POL];
  wire [3:0] irq_req = {printer_irq, floppy_irq, serial_irq_b,
                        serial_irq_a};
  wire [3:0] irq_high = {pol_high & ~ecp_epp, {3{pol_high}}};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq
      irq_pol_drive u_drv (
        .clk      (clk),
        .rst_n    (any_rst_n),
        .req      (irq_req[gi]),
        .act_high (irq_high[gi]),
        .pin_o    (irq_o[gi]),
        .pin_oe   (irq_oe[gi])
      );
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!any_rst_n) begin
      isa_rdata   <= 8'h00;
      isa_rd_hit  <= 1'b0;
      config_mode <= 1'b0;
      func_ctl    <= '0;
      port_ctl    <= '0;
      slot_sel    <= 2'h0;
      slot3_base  <= 10'h000;
      slot4_base  <= 10'h000;
    end else begin
      isa_rdata   <= cfg_rd ? rd_mux : 8'h00;
      isa_rd_hit  <= cfg_rd;
      config_mode <= (mode_nxt == cfg_pkg::CM_OPEN);
      func_ctl    <= func_nxt;
      port_ctl    <= port_nxt;
      slot_sel    <= slot_nxt;
      slot3_base  <= s3_nxt;
      slot4_base  <= s4_nxt;
    end
  end
endmodule

// *** test/superio_config_regs_assertions.sv ***
`timescale 1ns/100ps
module superio_config_regs_assertions (
  input wire logic               clk,          // Clock
  input wire logic               rst_n,        // Ordinary reset
  input wire logic               por_n,        // Power-up reset
  input wire logic [9:0]         isa_addr,     // I/O address
  input wire logic [7:0]         isa_wdata,    // Write data
  input wire logic               isa_iow,      // Write strobe
  input wire logic               isa_ior,      // Read strobe
  input wire logic               isa_rd_hit,   // Read claimed
  input wire logic               ext_mode_in,  // Extended mode
  input wire logic               serial_irq_a, // Serial request
  input wire logic               config_mode,  // Mode open
  input wire cfg_pkg::func_ctl_t func_ctl,     // Function controls
  input wire cfg_pkg::port_ctl_t port_ctl,     // Port controls
  input wire logic [3:0]         irq_o,        // Pin levels
  input wire logic [3:0]         irq_oe        // Pin enables
);
  // Decoded controls lag reset release, so wait before trusting them
  logic [1:0] up_cnt_r;
  always_ff @(posedge clk) begin
    if (!rst_n || !por_n) up_cnt_r <= 2'h0;
    else if (up_cnt_r != 2'h3) up_cnt_r <= up_cnt_r + 2'h1;
  end
  wire idx_wr = isa_iow && isa_addr == cfg_pkg::INDEX_PORT_ADDR;
  wire quit_wr = idx_wr && isa_wdata == cfg_pkg::EXIT_KEY;
  wire bus_idle = !isa_iow && !isa_ior;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);
  sequence s_key; idx_wr && isa_wdata == cfg_pkg::ENTER_KEY; endsequence
  sequence s_quit; idx_wr && isa_wdata == cfg_pkg::EXIT_KEY; endsequence
  // Idle cycles between the keys are legal and must not disarm
  sequence s_gap; bus_idle; endsequence
  property p_enter; s_key ##1 s_gap ##1 s_key |=> config_mode; endproperty
  a_enter: assert property (p_enter)
    else $error("entry keys did not open the mode");
  property p_no_enter;
    !config_mode && (isa_iow || isa_ior) &&
    isa_addr != cfg_pkg::INDEX_PORT_ADDR |=> !config_mode;
  endproperty
  a_no_enter: assert property (p_no_enter)
    else $error("mode opened after a foreign access");
  property p_exit; config_mode and s_quit |=> !config_mode; endproperty
  a_exit: assert property (p_exit)
    else $error("exit key did not close the mode");
  property p_hold; config_mode && !quit_wr |=> config_mode; endproperty
  a_hold: assert property (p_hold)
    else $error("mode closed without exit key");
  property p_rd_cause;
    isa_rd_hit |-> $past(isa_ior) && $past(config_mode) &&
    $past(isa_addr) == cfg_pkg::DATA_PORT_ADDR;
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read claimed without a data port read");
  property p_refused; isa_ior && !config_mode |=> !isa_rd_hit; endproperty
  a_refused: assert property (p_refused)
    else $error("read claimed outside the mode");
  property p_irq_a; irq_o[0] |-> irq_oe[0] && $past(serial_irq_a); endproperty
  a_irq_a: assert property (p_irq_a)
    else $error("serial pin high without request or drive");
  property p_printer_interrupt;
    up_cnt_r == 2'h3 && $past(ext_mode_in) && !port_ctl.pp_printer_mode
    |-> !irq_o[3];
  endproperty
  a_printer_interrupt: assert property (p_printer_interrupt)
    else $error("printer pin high in extended mode");
  property p_osc; func_ctl.osc_on == func_ctl.baud_clock_generator_en;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator and baud clock disagree");
endmodule

bind superio_config_regs superio_config_regs_assertions props (
  .clk(clk), .rst_n(rst_n), .por_n(por_n), .isa_addr(isa_addr),
  .isa_wdata(isa_wdata), .isa_iow(isa_iow), .isa_ior(isa_ior),
  .isa_rd_hit(isa_rd_hit), .ext_mode_in(ext_mode_in),
  .serial_irq_a(serial_irq_a), .config_mode(config_mode),
  .func_ctl(func_ctl), .port_ctl(port_ctl), .irq_o(irq_o), .irq_oe(irq_oe)
);

// *** test/isa_host_model.sv ***
`timescale 1ns/100ps
module isa_host_model (
  input  wire logic       clk,        // Clock
  output logic      [9:0] isa_addr,   // I/O address
  output logic      [7:0] isa_wdata,  // Write data
  output logic            isa_iow,    // Write strobe
  output logic            isa_ior,    // Read strobe
  input  wire logic [7:0] isa_rdata,  // Read data
  input  wire logic       isa_rd_hit  // Read claimed
);
  initial begin
    isa_addr = 10'h155;
    isa_wdata = 8'h5a;
    isa_iow = 1'b0;
    isa_ior = 1'b0;
  end
  // Idle bus shows inverted values so stale data never looks valid
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    isa_addr <= a;
    isa_wdata <= d;
    isa_iow <= 1'b1;
    @(posedge clk);
    isa_iow <= 1'b0;
    isa_addr <= ~a;
    isa_wdata <= ~d;
  endtask
  task automatic io_rd(input logic [9:0] a, output logic [7:0] d,
                       output logic h);
    @(posedge clk);
    isa_addr <= a;
    isa_ior <= 1'b1;
    @(posedge clk);
    isa_ior <= 1'b0;
    isa_addr <= ~a;
    #1;
    d = isa_rdata;
    h = isa_rd_hit;
  endtask
  task automatic enter();
    io_wr(cfg_pkg::INDEX_PORT_ADDR, cfg_pkg::ENTER_KEY);
    io_wr(cfg_pkg::INDEX_PORT_ADDR, cfg_pkg::ENTER_KEY);
  endtask
  task automatic leave();
    io_wr(cfg_pkg::INDEX_PORT_ADDR, cfg_pkg::EXIT_KEY);
  endtask
  task automatic cfg_wr(input logic [3:0] i, input logic [7:0] d);
    io_wr(cfg_pkg::INDEX_PORT_ADDR, {4'h0, i});
    io_wr(cfg_pkg::DATA_PORT_ADDR, i == 4'h0 ? d & 8'hfb : d);
  endtask
  task automatic cfg_rd(input logic [3:0] i, output logic [7:0] d,
                        output logic h);
    io_wr(cfg_pkg::INDEX_PORT_ADDR, {4'h0, i});
    io_rd(cfg_pkg::DATA_PORT_ADDR, d, h);
  endtask
endmodule

// *** test/superio_config_regs_test.sv ***
`timescale 1ns/100ps
module superio_config_regs_test;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               por_n = 1'b0;
  logic               power_good = 1'b1;
  logic               ext_mode_in = 1'b0;
  logic [3:0]         irq_req = 4'h0;
  wire  [9:0]         isa_addr, slot3_base, slot4_base;
  wire  [7:0]         isa_wdata, isa_rdata;
  wire                isa_iow, isa_ior, isa_rd_hit, config_mode;
  wire  [1:0]         slot_sel;
  wire  [3:0]         irq_o, irq_oe;
  cfg_pkg::func_ctl_t func_ctl;
  cfg_pkg::port_ctl_t port_ctl;
  int                 err_count = 0;
  int                 checked = 0;
  logic [31:0]        want;
  cfg_pkg::func_ctl_t alt_func;
  // Row: index, data, expected decode (see seen)
  logic [43:0]        rows [12] = '{
    {4'h0, 8'h80, 5'h00, 7'h07, 20'h00000},
    {4'h0, 8'hfb, 5'h00, 7'h79, 20'h00000},
    {4'h0, 8'h29, 5'h00, 7'h56, 20'h00000},
    {4'h0, 8'h52, 5'h00, 7'h2e, 20'h00000},
    {4'h1, 8'h9c, 2'h3, 10'h000, 10'h338, 10'h238},
    {4'h1, 8'ha1, 2'h0, 10'h3bc, 10'h3e8, 10'h2e8},
    {4'h1, 8'hd6, 2'h2, 10'h378, 10'h2e8, 10'h2e0},
    {4'h1, 8'hfb, 2'h1, 10'h278, 10'h220, 10'h228},
    {4'h2, 8'hdc, 8'h00, 4'hf, 10'h3f8, 10'h2f8},
    {4'h2, 8'h21, 8'h00, 4'h0, 10'h2f8, 10'h220},
    {4'h2, 8'h5e, 8'h00, 4'he, 10'h220, 10'h2f8},
    {4'h2, 8'hb7, 8'h00, 4'h9, 10'h228, 10'h228}};

  always #5 clk = ~clk;
  isa_host_model host (.clk(clk), .isa_addr(isa_addr), .isa_wdata(isa_wdata),
    .isa_iow(isa_iow), .isa_ior(isa_ior), .isa_rdata(isa_rdata),
    .isa_rd_hit(isa_rd_hit));
  superio_config_regs dut (.clk(clk), .rst_n(rst_n), .por_n(por_n),
    .isa_addr(isa_addr), .isa_wdata(isa_wdata), .isa_iow(isa_iow),
    .isa_ior(isa_ior), .isa_rdata(isa_rdata), .isa_rd_hit(isa_rd_hit),
    .power_good(power_good), .ext_mode_in(ext_mode_in),
    .serial_irq_a(irq_req[0]), .serial_irq_b(irq_req[1]),
    .floppy_irq(irq_req[2]), .printer_irq(irq_req[3]),
    .config_mode(config_mode), .func_ctl(func_ctl), .port_ctl(port_ctl),
    .slot_sel(slot_sel), .slot3_base(slot3_base), .slot4_base(slot4_base),
    .irq_o(irq_o), .irq_oe(irq_oe));
  // Second variant kept off the bus; only its defaults matter
  superio_config_regs #(.ALT_VARIANT(1'b1)) dut_alt (.clk(clk),
    .rst_n(rst_n), .por_n(por_n), .isa_addr(isa_addr),
    .isa_wdata(isa_wdata), .isa_iow(1'b0), .isa_ior(1'b0), .isa_rdata(),
    .isa_rd_hit(), .power_good(power_good), .ext_mode_in(1'b0),
    .serial_irq_a(1'b0), .serial_irq_b(1'b0), .floppy_irq(1'b0),
    .printer_irq(1'b0), .config_mode(), .func_ctl(alt_func),
    .port_ctl(), .slot_sel(), .slot3_base(), .slot4_base(), .irq_o(),
    .irq_oe());

  function automatic logic [31:0] seen(input logic [3:0] i);
    case (i)
      4'h0: seen = {5'h00, func_ctl, 20'h00000};
      4'h1: seen = {port_ctl.pp_pwr, port_ctl.pp_printer_mode,
        port_ctl.pp_en ? port_ctl.pp_base : 10'h000, slot3_base, slot4_base};
      default: seen = {8'h00, port_ctl.uart1_en, port_ctl.uart1_pwr,
        port_ctl.uart2_en, port_ctl.uart2_pwr, port_ctl.uart1_base,
        port_ctl.uart2_base};
    endcase
  endfunction
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [3:0] i, input logic [7:0] d,
                        input logic h);
    logic [7:0] rd;
    logic       hit;
    host.cfg_rd(i, rd, hit);
    chk("config read", {23'h0, h, d}, {23'h0, hit, rd});
  endtask
  task automatic pulse(input bit hard);
    @(posedge clk);
    if (hard) por_n <= 1'b0;
    else rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic irq_chk(input logic [7:0] exp);
    repeat (3) @(posedge clk);
    #1;
    chk("irq pins", {24'h0, exp}, {24'h0, irq_o, irq_oe});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    host.enter();
    for (int r = 0; r < 12; r++) begin
      host.cfg_wr(rows[r][43:40], rows[r][39:32]);
      rd_chk(rows[r][43:40], rows[r][39:32], 1'b1);
      want = rows[r][31:0];
      if (rows[r][43:40] == 4'h0) begin
        chk("func decode", want, seen(4'h0));
      end else if (rows[r][43:40] == 4'h1) begin
        chk("port decode", want, seen(4'h1));
        chk("slot sel", 32'(rows[r][38:37]), 32'(slot_sel));
      end else begin
        chk("uart", want, seen(4'h2));
      end
    end
    pulse(1'b0);
    host.enter();
    rd_chk(4'h0, 8'h52, 1'b1);
    rd_chk(4'h2, 8'hb7, 1'b1);
    @(posedge clk) irq_req <= 4'h1;
    irq_chk(8'h1f);
    host.cfg_wr(4'h1, 8'h87);
    irq_chk(8'h01);
    host.cfg_wr(4'h1, 8'h97);
    @(posedge clk) irq_req <= 4'h8;
    irq_chk(8'h8f);
    @(posedge clk) ext_mode_in <= 1'b1;
    irq_chk(8'h0f);
    @(posedge clk) irq_req <= 4'h0;
    ext_mode_in <= 1'b0;
    host.cfg_wr(4'h1, 8'h17);
    rd_chk(4'h1, 8'h00, 1'b0);
    host.cfg_wr(4'h1, 8'h9f);
    host.leave();
    pulse(1'b0);
    host.enter();
    rd_chk(4'h1, 8'h00, 1'b0);
    pulse(1'b1);
    host.enter();
    rd_chk(4'h0, 8'h3b, 1'b1);
    rd_chk(4'h1, 8'h9f, 1'b1);
    rd_chk(4'h2, 8'hdc, 1'b1);
    chk("function controls", 32'h7e, {25'h0, func_ctl});
    chk("alt function controls", 32'h76, {25'h0, alt_func});
    host.leave();
    #1 chk("mode", 32'h0, {31'h0, config_mode});
    rd_chk(4'h0, 8'h00, 1'b0);
    host.io_wr(cfg_pkg::INDEX_PORT_ADDR, cfg_pkg::ENTER_KEY);
    host.io_wr(10'h3f8, 8'h00);
    host.io_wr(cfg_pkg::INDEX_PORT_ADDR, cfg_pkg::ENTER_KEY);
    #1 chk("mode", 32'h0, {31'h0, config_mode});
    host.io_wr(cfg_pkg::INDEX_PORT_ADDR, cfg_pkg::ENTER_KEY);
    #1 chk("mode", 32'h1, {31'h0, config_mode});
    @(posedge clk) power_good <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("clocks", 32'h0, {30'h0, func_ctl.osc_on,
      func_ctl.baud_clock_generator_en});
    print_verdict();
  end
endmodule
